// ==== rtl/tirm_pkg.sv ====
package tirm_pkg;
    // ==========================================================
    // register map
    localparam logic [7:0] ADDR_SIGLOSS_IRQ_ENABLE = 8'h06;
    localparam logic [7:0] ADDR_FAULT_IRQ_ENABLE = 8'h07;
    localparam logic [7:0] ADDR_SIGLOSS_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_FAULT_IRQ_STATUS = 8'h09;
    localparam logic [7:0] ADDR_SOFT_RESET = 8'h0a;
    localparam logic [7:0] ADDR_MONITOR_SELECT = 8'h0b;
    // ==========================================================
    // reset values and fields
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [3:0] RST_MONITOR = 4'h0;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam logic [3:0] MON_RESERVED_ZERO = 4'h0;
    localparam logic [2:0] MON_CHAN_NONE = 3'h0;
    localparam int MON_DIR_BIT = 3;
    localparam int MON_CHAN_MSB = 2;
    localparam int MON_FIELD_MSB = 3;
    // ==========================================================
    // soft reset timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int SRST_SHORT_NS = 1000;
    localparam int SRST_LONG_NS = 2000;
    localparam int SRST_SHORT_CYC = (SRST_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SRST_LONG_CYC = (SRST_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SRST_CNT_W = 8;
    localparam logic [SRST_CNT_W-1:0] SRST_CNT_ZERO = 8'h00;
    localparam logic [SRST_CNT_W-1:0] SRST_CNT_ONE = 8'h01;
endpackage

// ==== rtl/tirm_change_flags.sv ====
`timescale 1ns/1ns
module tirm_change_flags #(
    parameter int WIDTH = 8
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic hold_default,
    input wire logic read_clear,
    input wire logic [WIDTH-1:0] det,
    output logic [WIDTH-1:0] flag_r
);
    logic [WIDTH-1:0] prev_r;
    logic primed_r;
    logic [WIDTH-1:0] chg;
    logic [WIDTH-1:0] flag_nxt;

    // first cycle after reset only loads the history, so a detector that
    // is already active at power-up does not raise a false change
    assign chg = primed_r ? (det ^ prev_r) : '0;
    // a change in the clearing cycle survives the clear
    assign flag_nxt = hold_default ? '0 : ((flag_r & ~{WIDTH{read_clear}}) | chg);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            prev_r <= '0;
            primed_r <= 1'b0;
            flag_r <= '0;
        end else begin
            prev_r <= det;
            primed_r <= 1'b1;
            flag_r <= flag_nxt;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    chk_flag_set: assert property (!hold_default && chg != '0
        |=> (flag_r & $past(chg)) == $past(chg))
        else $error("changed channel did not latch its flag");
    chk_flag_clear: assert property (read_clear && !hold_default && chg == '0
        |=> flag_r == '0)
        else $error("read did not clear pending flags");
endmodule

// ==== rtl/tirm_regs.sv ====
`timescale 1ns/1ns
module tirm_regs #(
    parameter int CHANNELS = 8
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic host_rd_strobe,
    input wire logic host_wr_strobe,
    input wire logic [7:0] host_addr,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    input wire logic host_nonmux_mode,
    input wire logic [CHANNELS-1:0] loss_of_signal,
    input wire logic [CHANNELS-1:0] driver_fault_monitor,
    output logic irq_out,
    output logic soft_reset_busy,
    output logic mon_rx_en,
    output logic mon_tx_en,
    output logic [2:0] mon_chan
);
    // ==========================================================
    // pin synchronisers
    logic rd_s1_r, rd_s2_r, rd_s3_r;
    logic wr_s1_r, wr_s2_r, wr_s3_r;
    logic mode_s1_r, mode_s2_r;
    logic [7:0] addr_s1_r, addr_s2_r;
    logic [7:0] data_s1_r, data_s2_r;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rd_s1_r <= 1'b0;
            rd_s2_r <= 1'b0;
            rd_s3_r <= 1'b0;
            wr_s1_r <= 1'b0;
            wr_s2_r <= 1'b0;
            wr_s3_r <= 1'b0;
            mode_s1_r <= 1'b0;
            mode_s2_r <= 1'b0;
            addr_s1_r <= 8'h00;
            addr_s2_r <= 8'h00;
            data_s1_r <= 8'h00;
            data_s2_r <= 8'h00;
        end else begin
            rd_s1_r <= host_rd_strobe;
            rd_s2_r <= rd_s1_r;
            rd_s3_r <= rd_s2_r;
            wr_s1_r <= host_wr_strobe;
            wr_s2_r <= wr_s1_r;
            wr_s3_r <= wr_s2_r;
            mode_s1_r <= host_nonmux_mode;
            mode_s2_r <= mode_s1_r;
            addr_s1_r <= host_addr;
            addr_s2_r <= addr_s1_r;
            data_s1_r <= host_data_in;
            data_s2_r <= data_s1_r;
        end
    end

    // ==========================================================
    // decode
    logic [tirm_pkg::SRST_CNT_W-1:0] srst_cnt_r, srst_cnt_nxt, srst_len;
    logic srst_active, wr_evt, rd_evt, wr_ok, srst_start;
    logic hit_sl_en, hit_flt_en, hit_sl_stat, hit_flt_stat, hit_srst, hit_mon;

    assign wr_evt = wr_s2_r & ~wr_s3_r;
    assign rd_evt = rd_s2_r & ~rd_s3_r;
    assign srst_active = srst_cnt_r != tirm_pkg::SRST_CNT_ZERO;
    // writes during the soft reset cycle are dropped; registers are pinned
    assign wr_ok = wr_evt & ~srst_active;
    assign hit_sl_en = addr_s2_r == tirm_pkg::ADDR_SIGLOSS_IRQ_ENABLE;
    assign hit_flt_en = addr_s2_r == tirm_pkg::ADDR_FAULT_IRQ_ENABLE;
    assign hit_sl_stat = addr_s2_r == tirm_pkg::ADDR_SIGLOSS_IRQ_STATUS;
    assign hit_flt_stat = addr_s2_r == tirm_pkg::ADDR_FAULT_IRQ_STATUS;
    assign hit_srst = addr_s2_r == tirm_pkg::ADDR_SOFT_RESET;
    assign hit_mon = addr_s2_r == tirm_pkg::ADDR_MONITOR_SELECT;

    // ==========================================================
    // soft reset cycle
    assign srst_start = wr_ok & hit_srst;
    // the slow strobe mode gets the longer cycle so the host's wait covers it
    assign srst_len = mode_s2_r ? tirm_pkg::SRST_CNT_W'(tirm_pkg::SRST_LONG_CYC)
                                : tirm_pkg::SRST_CNT_W'(tirm_pkg::SRST_SHORT_CYC);
    assign srst_cnt_nxt = srst_start ? srst_len
                        : srst_active ? srst_cnt_r - tirm_pkg::SRST_CNT_ONE
                        : tirm_pkg::SRST_CNT_ZERO;

    // ==========================================================
    // registers
    logic [CHANNELS-1:0] sl_en_r, flt_en_r, sl_flags, flt_flags;
    logic [tirm_pkg::MON_FIELD_MSB:0] mon_r;
    logic rd_clr_sl, rd_clr_flt, irq_nxt;
    logic [7:0] rdata_nxt;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            srst_cnt_r <= tirm_pkg::SRST_CNT_ZERO;
            sl_en_r <= CHANNELS'(tirm_pkg::RST_ENABLE);
            flt_en_r <= CHANNELS'(tirm_pkg::RST_ENABLE);
            mon_r <= tirm_pkg::RST_MONITOR;
        end else begin
            srst_cnt_r <= srst_cnt_nxt;
            if (srst_active) begin
                sl_en_r <= CHANNELS'(tirm_pkg::RST_ENABLE);
                flt_en_r <= CHANNELS'(tirm_pkg::RST_ENABLE);
                mon_r <= tirm_pkg::RST_MONITOR;
            end else if (wr_ok) begin
                if (hit_sl_en) begin
                    sl_en_r <= data_s2_r[CHANNELS-1:0];
                end
                if (hit_flt_en) begin
                    flt_en_r <= data_s2_r[CHANNELS-1:0];
                end
                if (hit_mon) begin
                    mon_r <= data_s2_r[tirm_pkg::MON_FIELD_MSB:0];
                end
            end
        end
    end

    assign rd_clr_sl = rd_evt & hit_sl_stat;
    assign rd_clr_flt = rd_evt & hit_flt_stat;

    tirm_change_flags #(.WIDTH(CHANNELS)) u_sigloss_flags (
        .core_clk(core_clk),
        .reset(reset),
        .hold_default(srst_active),
        .read_clear(rd_clr_sl),
        .det(loss_of_signal),
        .flag_r(sl_flags)
    );

    tirm_change_flags #(.WIDTH(CHANNELS)) u_fault_flags (
        .core_clk(core_clk),
        .reset(reset),
        .hold_default(srst_active),
        .read_clear(rd_clr_flt),
        .det(driver_fault_monitor),
        .flag_r(flt_flags)
    );

    // ==========================================================
    // read data, interrupt, monitor routing
    assign rdata_nxt = hit_sl_en ? 8'(sl_en_r)
                     : hit_flt_en ? 8'(flt_en_r)
                     : hit_sl_stat ? 8'(sl_flags)
                     : hit_flt_stat ? 8'(flt_flags)
                     : hit_mon ? {tirm_pkg::MON_RESERVED_ZERO, mon_r}
                     : tirm_pkg::READ_ZERO;
    assign irq_nxt = (|(sl_flags & sl_en_r)) | (|(flt_flags & flt_en_r));

    always_ff @(posedge core_clk) begin
        if (reset) begin
            host_data_out <= tirm_pkg::READ_ZERO;
            host_data_oe <= 1'b0;
            irq_out <= 1'b0;
            soft_reset_busy <= 1'b0;
            mon_rx_en <= 1'b0;
            mon_tx_en <= 1'b0;
            mon_chan <= tirm_pkg::MON_CHAN_NONE;
        end else begin
            if (rd_evt) begin
                host_data_out <= rdata_nxt;
            end
            host_data_oe <= rd_s2_r;
            irq_out <= irq_nxt;
            soft_reset_busy <= srst_active;
            mon_chan <= mon_r[tirm_pkg::MON_CHAN_MSB:0];
            // zero channel selects nothing in either direction
            mon_rx_en <= ~mon_r[tirm_pkg::MON_DIR_BIT]
                       & (mon_r[tirm_pkg::MON_CHAN_MSB:0] != tirm_pkg::MON_CHAN_NONE);
            mon_tx_en <= mon_r[tirm_pkg::MON_DIR_BIT]
                       & (mon_r[tirm_pkg::MON_CHAN_MSB:0] != tirm_pkg::MON_CHAN_NONE);
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence srst_short_s;
        srst_active [*8] ##42 srst_active ##1 !srst_active;
    endsequence
    sequence srst_long_s;
        srst_active [*8] ##92 srst_active ##1 !srst_active;
    endsequence

    chk_flt_en_write: assert property (wr_ok && hit_flt_en |=> flt_en_r == $past(data_s2_r))
        else $error("fault enable write not stored");
    chk_sl_en_write: assert property (wr_ok && hit_sl_en |=> sl_en_r == $past(data_s2_r))
        else $error("signal loss enable write not stored");
    chk_power_up: assert property (disable iff (1'b0) $past(reset) |->
        flt_en_r == '0 && sl_en_r == '0 && sl_flags == '0 && flt_flags == '0)
        else $error("register not cleared by power-up reset");
    chk_srst_short: assert property (srst_start && !mode_s2_r |=> srst_short_s)
        else $error("short soft reset cycle has wrong length");
    chk_srst_long: assert property (srst_start && mode_s2_r |=> srst_long_s)
        else $error("long soft reset cycle has wrong length");
    chk_srst_defaults: assert property (srst_active |=> sl_en_r == '0 && flt_en_r == '0
        && mon_r == tirm_pkg::RST_MONITOR && sl_flags == '0 && flt_flags == '0)
        else $error("soft reset did not restore defaults");
    chk_irq_enabled: assert property (
        (sl_flags & sl_en_r) != '0 || (flt_flags & flt_en_r) != '0 |=> irq_out)
        else $error("enabled flag did not raise interrupt");
    chk_irq_quiet: assert property (sl_flags == '0 && flt_flags == '0 |=> !irq_out)
        else $error("interrupt without pending flag");
    chk_mon_reserved: assert property (rd_evt && hit_mon |=> host_data_out[7:4] == 4'h0)
        else $error("reserved monitor bits read nonzero");
    chk_mon_off: assert property (
        mon_r[tirm_pkg::MON_CHAN_MSB:0] == tirm_pkg::MON_CHAN_NONE |=> !mon_rx_en && !mon_tx_en)
        else $error("monitoring active with zero select");
    chk_mon_rx: assert property (!mon_r[tirm_pkg::MON_DIR_BIT] && mon_r[2:0] != 3'h0
        |=> mon_rx_en && !mon_tx_en && mon_chan == $past(mon_r[2:0]))
        else $error("receiver not routed to monitor");
    chk_mon_tx: assert property (mon_r[tirm_pkg::MON_DIR_BIT] && mon_r[2:0] != 3'h0
        |=> mon_tx_en && !mon_rx_en && mon_chan == $past(mon_r[2:0]))
        else $error("transmitter not routed to monitor");
endmodule

// ==== testbench/tirm_host_model.sv ====
`timescale 1ns/1ns
// ==========================================================
// host side of the strobe bus
module tirm_host_model (
    input wire logic core_clk,
    input wire logic [7:0] host_data_out,
    input wire logic host_data_oe,
    output logic host_rd_strobe,
    output logic host_wr_strobe,
    output logic [7:0] host_addr,
    output logic [7:0] host_data_in
);
    initial begin
        host_rd_strobe = 1'b0;
        host_wr_strobe = 1'b0;
        host_addr = 8'h00;
        host_data_in = 8'h00;
    end

    // address and data lead the strobe: they pass the same sync stages
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        host_addr <= a;
        host_data_in <= d;
        repeat (3) @(posedge core_clk);
        host_wr_strobe <= 1'b1;
        repeat (4) @(posedge core_clk);
        host_wr_strobe <= 1'b0;
        repeat (3) @(posedge core_clk);
        // released bus: show the inverse so stale data never looks right
        host_data_in <= ~d;
        repeat (3) @(posedge core_clk);
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output bit ok);
        int n;
        ok = 1'b0;
        d = 8'h00;
        @(posedge core_clk);
        host_addr <= a;
        repeat (3) @(posedge core_clk);
        host_rd_strobe <= 1'b1;
        // data is launched with the enable, so both are taken at the edge that sees it
        for (n = 0; n < 8 && !ok; n++) begin
            @(posedge core_clk);
            ok = (host_data_oe === 1'b1);
        end
        d = host_data_out;
        host_rd_strobe <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
endmodule

// ==== testbench/tirm_regs_tb.sv ====
`timescale 1ns/1ns
module tirm_regs_tb;
    logic core_clk, reset, nonmux, irq_out, busy, mon_rx_en, mon_tx_en, rd_s, wr_s, oe;
    logic [7:0] addr, din, dout, sloss, fault, v;
    logic [2:0] mon_chan;
    int fail_count = 0;
    int samples_checked = 0;
    int busy_cycles = 0;
    int i;

    tirm_regs uut (.core_clk(core_clk), .reset(reset), .host_rd_strobe(rd_s),
        .host_wr_strobe(wr_s), .host_addr(addr), .host_data_in(din), .host_data_out(dout),
        .host_data_oe(oe), .host_nonmux_mode(nonmux), .loss_of_signal(sloss),
        .driver_fault_monitor(fault), .irq_out(irq_out), .soft_reset_busy(busy),
        .mon_rx_en(mon_rx_en), .mon_tx_en(mon_tx_en), .mon_chan(mon_chan));
    tirm_host_model host (.core_clk(core_clk), .host_data_out(dout), .host_data_oe(oe),
        .host_rd_strobe(rd_s), .host_wr_strobe(wr_s), .host_addr(addr), .host_data_in(din));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (busy === 1'b1) busy_cycles++;

    // ==========================================================
    // checking and closing
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        bit ok;
        host.rd_reg(a, d, ok);
        if (!ok) begin
            fail_count++;
            end_of_test;
        end
        check(d, exp);
    endtask
    task automatic settle;
        repeat (3) @(posedge core_clk);
    endtask

    // ==========================================================
    // tests
    initial begin
        reset = 1'b1;
        nonmux = 1'b0;
        sloss = 8'h00;
        fault = 8'h00;
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        for (i = 0; i < 8; i++) rd(tirm_pkg::ADDR_SIGLOSS_IRQ_ENABLE + 8'(i), 8'h00);
        rd(8'h20, 8'h00);
        $display("reset values done");
        host.wr_reg(tirm_pkg::ADDR_SIGLOSS_IRQ_ENABLE, 8'h5a);
        host.wr_reg(tirm_pkg::ADDR_FAULT_IRQ_ENABLE, 8'ha5);
        rd(tirm_pkg::ADDR_SIGLOSS_IRQ_ENABLE, 8'h5a);
        rd(tirm_pkg::ADDR_FAULT_IRQ_ENABLE, 8'ha5);
        // masked receiver 0, then enabled receiver 3
        sloss <= 8'h01;
        settle;
        check({7'h00, irq_out}, 8'h00);
        rd(tirm_pkg::ADDR_SIGLOSS_IRQ_STATUS, 8'h01);
        sloss <= 8'h09;
        settle;
        check({7'h00, irq_out}, 8'h01);
        rd(tirm_pkg::ADDR_SIGLOSS_IRQ_STATUS, 8'h08);
        rd(tirm_pkg::ADDR_SIGLOSS_IRQ_STATUS, 8'h00);
        // a receiver leaving loss must flag as well
        sloss <= 8'h08;
        settle;
        rd(tirm_pkg::ADDR_SIGLOSS_IRQ_STATUS, 8'h01);
        check({7'h00, irq_out}, 8'h00);
        fault <= 8'h81;
        settle;
        check({7'h00, irq_out}, 8'h01);
        rd(tirm_pkg::ADDR_FAULT_IRQ_STATUS, 8'h81);
        rd(tirm_pkg::ADDR_FAULT_IRQ_STATUS, 8'h00);
        fault <= 8'h01;
        settle;
        rd(tirm_pkg::ADDR_FAULT_IRQ_STATUS, 8'h80);
        host.wr_reg(tirm_pkg::ADDR_SIGLOSS_IRQ_STATUS, 8'hff);
        rd(tirm_pkg::ADDR_SIGLOSS_IRQ_STATUS, 8'h00);
        $display("flags and interrupt done");
        for (i = 0; i < 16; i++) begin
            v = 8'(i);
            host.wr_reg(tirm_pkg::ADDR_MONITOR_SELECT, 8'ha0 | v);
            rd(tirm_pkg::ADDR_MONITOR_SELECT, v);
            check({5'h00, mon_chan}, {5'h00, v[2:0]});
            check({7'h00, mon_rx_en}, {7'h00, !v[3] && v[2:0] != 3'h0});
            check({7'h00, mon_tx_en}, {7'h00, v[3] && v[2:0] != 3'h0});
        end
        $display("monitor select done");
        for (i = 0; i < 2; i++) begin
            nonmux <= i[0];
            host.wr_reg(tirm_pkg::ADDR_FAULT_IRQ_ENABLE, 8'hff);
            host.wr_reg(tirm_pkg::ADDR_MONITOR_SELECT, 8'h05);
            // leave a fault flag pending so the soft reset has one to clear
            fault <= fault ^ 8'h02;
            busy_cycles = 0;
            host.wr_reg(tirm_pkg::ADDR_SOFT_RESET, 8'h3c);
            // host waits out the whole cycle before trusting contents
            for (int n = 0; n < 300 && busy !== 1'b0; n++) @(posedge core_clk);
            if (busy !== 1'b0) begin
                fail_count++;
                end_of_test;
            end
            check(busy_cycles[7:0], i ? 8'h64 : 8'h32);
            rd(tirm_pkg::ADDR_FAULT_IRQ_ENABLE, 8'h00);
            rd(tirm_pkg::ADDR_MONITOR_SELECT, 8'h00);
            rd(tirm_pkg::ADDR_SIGLOSS_IRQ_ENABLE, 8'h00);
            rd(tirm_pkg::ADDR_FAULT_IRQ_STATUS, 8'h00);
            check({7'h00, irq_out}, 8'h00);
            rd(tirm_pkg::ADDR_SOFT_RESET, 8'h00);
        end
        $display("soft reset done");
        end_of_test;
    end
endmodule
